// File: dv/pps_mgmt_model.sv
// Management controller model that issues status word reads.
// Assumes one core clock; requests change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pps_mgmt_model (
    input wire logic core_clk_in,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_valid_in,
    output logic rd_out,
    output logic [4:0] addr_out
);
    // Reserved positions are masked since a controller may not rely on them.
    localparam logic [15:0] RSV_MASK = 16'hC48B;
    initial begin
        rd_out = 1'b0;
        addr_out = 5'h00;
    end
    task automatic do_read(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(negedge core_clk_in);
        rd_out = 1'b1;
        addr_out = a;
        @(posedge core_clk_in);
        #1;
        ok = rd_valid_in;
        d = rd_data_in & ~RSV_MASK;
        @(negedge core_clk_in);
        rd_out = 1'b0;
        addr_out = ~a;
    endtask
endmodule // pps_mgmt_model
`default_nettype wire

// File: dv/pps_port_status_checker.sv
// Assertions on the status word read port and strap outputs.
// Assumes it is bound to pps_port_status with one core clock.
`timescale 1ns/1ps
`default_nettype none
module pps_port_status_checker
    import pps_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic mgmt_rd_in,
    input wire logic [4:0] mgmt_addr_in,
    input wire logic [15:0] mgmt_rd_data_out,
    input wire logic mgmt_rd_valid_out,
    input wire logic link_up_in,
    input wire logic full_duplex_in,
    input wire logic speed_100_in,
    input wire logic an_complete_in,
    input wire logic page_received_in,
    input wire logic tx100_mode_in,
    input wire logic descrambler_locked_in,
    input wire logic symbol_error_in,
    input wire logic mlt3_error_in,
    input wire logic low_voltage_in,
    input wire logic link_test_disable_out,
    input wire logic strap_done_out,
    input wire logic basic_an_complete_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    logic st_rd;
    assign st_rd = mgmt_rd_in && (mgmt_addr_in == PPS_ADDR_STATUS);
    sequence s_sym_seen;
        symbol_error_in ##1 !mgmt_rd_in [*2] ##1 st_rd;
    endsequence
    a_valid_one_cycle: assert property (mgmt_rd_in |=> mgmt_rd_valid_out)
        else $error("read answer missing");
    a_valid_needs_read: assert property (mgmt_rd_valid_out |-> $past(mgmt_rd_in))
        else $error("answer without read");
    a_mode_bits: assert property (st_rd |=>
        mgmt_rd_data_out[12:11] == $past({full_duplex_in, speed_100_in}))
        else $error("mode bits wrong");
    a_link_live: assert property (st_rd |=> mgmt_rd_data_out[13] == $past(link_up_in))
        else $error("link bit wrong");
    a_an_done: assert property (st_rd |=> mgmt_rd_data_out[9] == $past(an_complete_in))
        else $error("an bit wrong");
    a_basic_mirror: assert property (!$past(srst_in) |->
        basic_an_complete_out == $past(an_complete_in))
        else $error("basic mirror wrong");
    a_page_rx: assert property (st_rd |=> mgmt_rd_data_out[8] == $past(page_received_in))
        else $error("page bit wrong");
    a_cipher_lock: assert property (st_rd |=>
        mgmt_rd_data_out[6] == $past(tx100_mode_in && descrambler_locked_in))
        else $error("cipher bit wrong");
    a_symbol_held: assert property (s_sym_seen |=> mgmt_rd_data_out[5])
        else $error("symbol flag lost");
    a_mlt3_set: assert property (st_rd && mlt3_error_in |=> mgmt_rd_data_out[4])
        else $error("mlt3 flag lost");
    a_lowv_set: assert property (st_rd && low_voltage_in |=> mgmt_rd_data_out[2])
        else $error("low voltage flag lost");
    a_reserved_zero: assert property (mgmt_rd_valid_out |->
        (mgmt_rd_data_out & 16'hC48B) == 16'h0000)
        else $error("reserved bits set");
    a_straps_hold: assert property (strap_done_out |=>
        strap_done_out && $stable(link_test_disable_out))
        else $error("strap default moved");
endmodule // pps_port_status_checker
bind pps_port_status pps_port_status_checker pps_port_status_checker_i (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .mgmt_rd_in(mgmt_rd_in),
    .mgmt_addr_in(mgmt_addr_in), .mgmt_rd_data_out(mgmt_rd_data_out),
    .mgmt_rd_valid_out(mgmt_rd_valid_out), .link_up_in(link_up_in),
    .full_duplex_in(full_duplex_in), .speed_100_in(speed_100_in),
    .an_complete_in(an_complete_in), .page_received_in(page_received_in),
    .tx100_mode_in(tx100_mode_in), .descrambler_locked_in(descrambler_locked_in),
    .symbol_error_in(symbol_error_in), .mlt3_error_in(mlt3_error_in),
    .low_voltage_in(low_voltage_in), .link_test_disable_out(link_test_disable_out),
    .strap_done_out(strap_done_out), .basic_an_complete_out(basic_an_complete_out));
`default_nettype wire

// File: dv/pps_port_status_tb.sv
// Self-checking bench for the per-port status word.
// Assumes the checker is bound and the controller model drives reads.
`timescale 1ns/1ps
`default_nettype none
module pps_port_status_tb;
    import pps_pkg::*;
    logic clk, rst, rd, valid, lnk, fd, sp, ane, anc, pg, tx, lk, se, me, lv;
    logic lts, bps, fbs, ltd, byp, fib, fib2, sdone, banc;
    logic [4:0] addr;
    logic [15:0] data;
    int miscompares = 0;
    int comparisons = 0;
    pps_port_status pps_port_status_i (.core_clk_in(clk), .srst_in(rst), .mgmt_rd_in(rd),
        .mgmt_addr_in(addr), .mgmt_rd_data_out(data), .mgmt_rd_valid_out(valid),
        .link_up_in(lnk), .full_duplex_in(fd), .speed_100_in(sp), .an_enable_in(ane),
        .an_complete_in(anc), .page_received_in(pg), .tx100_mode_in(tx),
        .descrambler_locked_in(lk), .symbol_error_in(se), .mlt3_error_in(me),
        .low_voltage_in(lv), .link_test_strap_in(lts), .scrambler_bypass_strap_in(bps),
        .fiber_select_strap_in(fbs), .link_test_disable_out(ltd),
        .scrambler_bypass_out(byp), .fiber_select_out(fib), .strap_done_out(sdone),
        .basic_an_complete_out(banc));
    pps_mgmt_model pps_mgmt_model_i (.core_clk_in(clk), .rd_data_in(data),
        .rd_valid_in(valid), .rd_out(rd), .addr_out(addr));
    // A second port on the partial-fiber variant, where port 2 is twisted-pair only.
    if (1) begin : tp_only_g
        pps_port_status #(.PORT_INDEX(2), .PARTIAL_FIBER_VARIANT(1'b1)) pps_port_status_i (
            .core_clk_in(clk), .srst_in(rst), .mgmt_rd_in(rd), .mgmt_addr_in(addr),
            .mgmt_rd_data_out(), .mgmt_rd_valid_out(), .link_up_in(lnk),
            .full_duplex_in(fd), .speed_100_in(sp), .an_enable_in(ane),
            .an_complete_in(anc), .page_received_in(pg), .tx100_mode_in(tx),
            .descrambler_locked_in(lk), .symbol_error_in(se), .mlt3_error_in(me),
            .low_voltage_in(lv), .link_test_strap_in(lts), .scrambler_bypass_strap_in(bps),
            .fiber_select_strap_in(fbs), .link_test_disable_out(),
            .scrambler_bypass_out(), .fiber_select_out(fib2), .strap_done_out(),
            .basic_an_complete_out());
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string name);
        logic [15:0] d;
        logic ok;
        pps_mgmt_model_i.do_read(a, d, ok);
        check("valid", {15'h0000, ok}, 16'h0001);
        check(name, d, exp);
    endtask
    task automatic strap_case(input logic [3:0] v, input logic [2:0] exp);
        int n;
        rst = 1'b1;
        {ane, lts, bps, fbs} = v;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (n = 0; n < 20 && sdone !== 1'b1; n++) @(negedge clk);
        check("straps", {13'h0000, ltd, byp, fib}, {13'h0000, exp});
        check("tp_only", {15'h0000, fib2}, 16'h0000);
    endtask
    task automatic t_straps;
        strap_case(4'b0110, 3'b110);
        strap_case(4'b1101, 3'b001);
        $display("t_straps done");
    endtask
    task automatic t_live;
        logic [6:0] tbl [6] = '{7'h7F, 7'h00, 7'h55, 7'h2A, 7'h7E, 7'h01};
        foreach (tbl[i]) begin
            {lnk, fd, sp, anc, pg, tx, lk} = tbl[i];
            rd_chk(PPS_ADDR_STATUS, {2'b00, tbl[i][6:4], 1'b0, tbl[i][3:2], 1'b0,
                tbl[i][1] & tbl[i][0], 6'h00}, "live");
            check("basic_an", {15'h0000, banc}, {15'h0000, tbl[i][3]});
        end
        $display("t_live done");
    endtask
    task automatic t_latch;
        {se, me, lv} = 3'b111;
        @(negedge clk);
        {se, me, lv} = 3'b000;
        @(negedge clk);
        rd_chk(PPS_ADDR_STATUS, 16'h0034, "latched");
        rd_chk(PPS_ADDR_STATUS, 16'h0000, "cleared");
        {me, lv} = 2'b11;
        rd_chk(PPS_ADDR_STATUS, 16'h0014, "held_1");
        rd_chk(PPS_ADDR_STATUS, 16'h0014, "held_2");
        {me, lv} = 2'b00;
        rd_chk(PPS_ADDR_STATUS, 16'h0014, "released");
        rd_chk(PPS_ADDR_STATUS, 16'h0000, "current");
        $display("t_latch done");
    endtask
    task automatic t_unmapped;
        {lnk, fd, sp, anc, pg, tx, lk} = 7'h7F;
        rd_chk(5'h13, 16'h0000, "unmapped");
        $display("t_unmapped done");
    endtask
    initial begin
        rst = 1'b1;
        {lnk, fd, sp, ane, anc, pg, tx, lk, se, me, lv, lts, bps, fbs} = 14'h0000;
        t_straps;
        {lnk, fd, sp, anc, pg, tx, lk} = 7'h00;
        t_latch;
        t_live;
        t_unmapped;
        results;
    end
    initial begin
        #(4000 * 25);
        miscompares++;
        results;
    end
endmodule // pps_port_status_tb
`default_nettype wire

// File: verilog/pps_pkg.sv
// Package for the per-port status word of one transceiver port.
// Assumes a single core clock domain and a synchronous, active-high reset.
package pps_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] PPS_ADDR_STATUS = 5'h14;
    localparam int PPS_DATA_W = 16;
    localparam logic [15:0] PPS_STATUS_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------------
    localparam int PPS_BIT_LINK = 13;
    localparam int PPS_BIT_DUPLEX = 12;
    localparam int PPS_BIT_SPEED = 11;
    localparam int PPS_BIT_AN_DONE = 9;
    localparam int PPS_BIT_PAGE_RX = 8;
    localparam int PPS_BIT_CIPHER_LOCK = 6;
    localparam int PPS_BIT_SYMBOL_ERR = 5;
    localparam int PPS_BIT_MLT3_ERR = 4;
    localparam int PPS_BIT_LOW_VOLT = 2;

    // ------------------------------------------------------------------
    // Latching-high flag indices
    // ------------------------------------------------------------------
    localparam int PPS_LH_SYMBOL = 0;
    localparam int PPS_LH_MLT3 = 1;
    localparam int PPS_LH_LOWV = 2;
    localparam int PPS_LH_COUNT = 3;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    localparam int PPS_SYNC_STAGES = 3;
    localparam int PPS_STRAP_COUNT = 3;
    localparam logic [2:0] PPS_STRAP_SETTLE_CYCLES = 3'h4;
    localparam logic [2:0] PPS_CNT_ZERO = 3'h0;
    localparam logic [2:0] PPS_CNT_ONE = 3'h1;
    localparam int PPS_STRAP_LINK_TEST = 0;
    localparam int PPS_STRAP_BYPASS = 1;
    localparam int PPS_STRAP_FIBER = 2;

    typedef enum logic [1:0] {
        PPS_ST_RESET = 2'b00,
        PPS_ST_SETTLE = 2'b01,
        PPS_ST_DONE = 2'b11
    } pps_strap_state_type;

endpackage : pps_pkg

// File: verilog/pps_port_status.sv
// Per-port status word and strap-derived configuration defaults of one port.
// Assumes datapath indications arrive on core_clk_in; strap pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module pps_port_status
    import pps_pkg::*;
#(
    parameter int PORT_INDEX = 0,
    parameter bit PARTIAL_FIBER_VARIANT = 1'b0
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Management read access.
    input wire logic mgmt_rd_in,
    input wire logic [4:0] mgmt_addr_in,
    output logic [15:0] mgmt_rd_data_out,
    output logic mgmt_rd_valid_out,
    // Datapath indications on the core clock.
    input wire logic link_up_in,
    input wire logic full_duplex_in,
    input wire logic speed_100_in,
    input wire logic an_enable_in,
    input wire logic an_complete_in,
    input wire logic page_received_in,
    input wire logic tx100_mode_in,
    input wire logic descrambler_locked_in,
    input wire logic symbol_error_in,
    input wire logic mlt3_error_in,
    input wire logic low_voltage_in,
    // Strap pins, asynchronous.
    input wire logic link_test_strap_in,
    input wire logic scrambler_bypass_strap_in,
    input wire logic fiber_select_strap_in,
    // Configuration defaults and status mirrors.
    output logic link_test_disable_out,
    output logic scrambler_bypass_out,
    output logic fiber_select_out,
    output logic strap_done_out,
    output logic basic_an_complete_out
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic port_is_tp_only(input int idx, input bit partial);
        port_is_tp_only = partial && ((idx == 0) || (idx == 2));
    endfunction

    // ------------------------------------------------------------------
    // Strap synchronisation
    // ------------------------------------------------------------------
    logic [PPS_STRAP_COUNT-1:0] strap_pins, strap_level;

    always_comb begin
        strap_pins = '0;
        strap_pins[PPS_STRAP_LINK_TEST] = link_test_strap_in;
        strap_pins[PPS_STRAP_BYPASS] = scrambler_bypass_strap_in;
        strap_pins[PPS_STRAP_FIBER] = fiber_select_strap_in;
    end

    pps_strap_sync #(
        .WIDTH(PPS_STRAP_COUNT)
    ) u_strap_sync (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .pin_in(strap_pins),
        .level_out(strap_level)
    );

    // ------------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------------
    // Straps are only sampled once the synchroniser has filled, so a reset
    // never loads a pin level directly into a flop.
    pps_strap_state_type st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic lt_dis_q, lt_dis_d;
    logic bypass_q, bypass_d;
    logic fiber_q, fiber_d;
    logic done_q, done_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        lt_dis_d = lt_dis_q;
        bypass_d = bypass_q;
        fiber_d = fiber_q;
        case (st_q)
            PPS_ST_RESET: begin
                cnt_d = PPS_STRAP_SETTLE_CYCLES;
                st_d = PPS_ST_SETTLE;
            end
            PPS_ST_SETTLE: begin
                if (cnt_q == PPS_CNT_ZERO) begin
                    if (an_enable_in) begin
                        lt_dis_d = 1'b0;
                    end else begin
                        lt_dis_d = strap_level[PPS_STRAP_LINK_TEST];
                    end
                    bypass_d = strap_level[PPS_STRAP_BYPASS];
                    if (port_is_tp_only(PORT_INDEX, PARTIAL_FIBER_VARIANT)) begin
                        fiber_d = 1'b0;
                    end else begin
                        fiber_d = strap_level[PPS_STRAP_FIBER];
                    end
                    st_d = PPS_ST_DONE;
                end else begin
                    cnt_d = cnt_q - PPS_CNT_ONE;
                end
            end
            PPS_ST_DONE: begin
                st_d = PPS_ST_DONE;
            end
            default: begin
                st_d = PPS_ST_RESET;
            end
        endcase
        // The done flag is registered so the output comes straight from a flop.
        done_d = (st_d == PPS_ST_DONE);
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st_q <= PPS_ST_RESET;
            cnt_q <= PPS_CNT_ZERO;
            lt_dis_q <= 1'b0;
            bypass_q <= 1'b0;
            fiber_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            done_q <= done_d;
            cnt_q <= cnt_d;
            lt_dis_q <= lt_dis_d;
            bypass_q <= bypass_d;
            fiber_q <= fiber_d;
        end
    end

    // ------------------------------------------------------------------
    // Latching-high flags
    // ------------------------------------------------------------------
    logic [PPS_LH_COUNT-1:0] lh_event, lh_q, lh_d;
    logic status_read;

    assign status_read = mgmt_rd_in && (mgmt_addr_in == PPS_ADDR_STATUS);

    always_comb begin
        lh_event = '0;
        lh_event[PPS_LH_SYMBOL] = symbol_error_in;
        lh_event[PPS_LH_MLT3] = mlt3_error_in;
        lh_event[PPS_LH_LOWV] = low_voltage_in;
    end

    // A status word read clears the held value, but an event in the read cycle wins,
    // so nothing that happens during the read is lost.
    always_comb begin
        lh_d = lh_q;
        for (int i = 0; i < PPS_LH_COUNT; i++) begin
            lh_d[i] = lh_event[i] | (lh_q[i] & ~status_read);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            lh_q <= '0;
        end else begin
            lh_q <= lh_d;
        end
    end

    // ------------------------------------------------------------------
    // Status word and read port
    // ------------------------------------------------------------------
    logic [15:0] status_word;
    logic [15:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic an_done_q, an_done_d;

    assign an_done_d = an_complete_in;

    always_comb begin
        status_word = PPS_STATUS_RESET;
        status_word[PPS_BIT_LINK] = link_up_in;
        status_word[PPS_BIT_DUPLEX] = full_duplex_in;
        status_word[PPS_BIT_SPEED] = speed_100_in;
        status_word[PPS_BIT_AN_DONE] = an_complete_in;
        status_word[PPS_BIT_PAGE_RX] = page_received_in;
        status_word[PPS_BIT_CIPHER_LOCK] = tx100_mode_in & descrambler_locked_in;
        status_word[PPS_BIT_SYMBOL_ERR] = lh_q[PPS_LH_SYMBOL] | lh_event[PPS_LH_SYMBOL];
        status_word[PPS_BIT_MLT3_ERR] = lh_q[PPS_LH_MLT3] | lh_event[PPS_LH_MLT3];
        status_word[PPS_BIT_LOW_VOLT] = lh_q[PPS_LH_LOWV] | lh_event[PPS_LH_LOWV];
    end

    // Unmapped addresses answer with zero so the controller never stalls.
    always_comb begin
        rd_valid_d = mgmt_rd_in;
        rd_data_d = rd_data_q;
        if (mgmt_rd_in) begin
            rd_data_d = status_read ? status_word : PPS_STATUS_RESET;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rd_data_q <= PPS_STATUS_RESET;
            rd_valid_q <= 1'b0;
            an_done_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            an_done_q <= an_done_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign mgmt_rd_data_out = rd_data_q;
    assign mgmt_rd_valid_out = rd_valid_q;
    assign link_test_disable_out = lt_dis_q;
    assign scrambler_bypass_out = bypass_q;
    assign fiber_select_out = fiber_q;
    assign strap_done_out = done_q;
    assign basic_an_complete_out = an_done_q;

    initial begin
        if (PORT_INDEX < 0 || PORT_INDEX > 3) begin
            $error("pps_port_status: PORT_INDEX must be 0 to 3.");
        end
    end

endmodule // pps_port_status
`default_nettype wire

// File: verilog/pps_strap_sync.sv
// Three-stage synchroniser for asynchronous strap pins.
// Assumes the pins are static levels; a change is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pps_strap_sync #(
    parameter int WIDTH = 3
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q;
    logic [WIDTH-1:0] level_d;

    always_comb begin
        level_d = level_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                level_d[i] = s3_q[i];
            end
        end
    end

    // The first stage feeds only the second; no logic looks at it.
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;

    initial begin
        if (WIDTH < 1) begin
            $error("pps_strap_sync: WIDTH must be at least 1.");
        end
    end
endmodule // pps_strap_sync
`default_nettype wire
